// ===== rtl/mspk_pkg.sv
// Purpose: shared constants for the stack/carry/memory-reference datapath slice
// Assumes: big-endian bit numbering in the description maps to [15:0] with bit 0 as msb
// Notes: phase encoding is the click cycle number minus one
package mspk_pkg;
    localparam int MSPK_DW = 16;
    localparam int MSPK_HW = 8;
    localparam int MSPK_AW = 20;
    localparam int MSPK_PW = 4;
    localparam int MSPK_NRH = 16;
    localparam logic [1:0] MSPK_PH_C1 = 2'h0;
    localparam logic [1:0] MSPK_PH_C2 = 2'h1;
    localparam logic [1:0] MSPK_PH_C3 = 2'h2;
    localparam logic [3:0] MSPK_FORCE_FN = 4'h3;
    localparam logic [3:0] MSPK_PTR_RST = 4'h0;
    localparam int MSPK_PTR_LSB = 0;
    localparam logic [MSPK_AW-1:0] MSPK_MAP_BASE = 20'h1_0000;
    typedef enum logic [2:0] {MSPK_SRC_AQ, MSPK_SRC_AB, MSPK_SRC_ZQ, MSPK_SRC_ZB,
        MSPK_SRC_ZA, MSPK_SRC_DA, MSPK_SRC_DQ, MSPK_SRC_DZ} mspk_src_e;
    typedef enum logic [2:0] {MSPK_FN_ADD, MSPK_FN_SUBR, MSPK_FN_SUBS, MSPK_FN_OR,
        MSPK_FN_AND, MSPK_FN_NOTRS, MSPK_FN_XOR, MSPK_FN_XNOR} mspk_fn_e;
endpackage : mspk_pkg

// ===== rtl/mspk_mem_if.sv
// Purpose: link between the processor slice and the memory controller card
// Assumes: one clock; phase is the processor's click phase
// Notes: none
`timescale 1ns/100ps
interface mspk_mem_if;
    logic [1:0] phase;
    logic mem_op;
    logic map_ref;
    logic [7:0] high_address_bus;
    logic [15:0] y_bus;
    logic [15:0] read_data;
    logic error;
    modport cpu (output phase, output mem_op, output map_ref, output high_address_bus,
        output y_bus, input read_data, input error);
    modport mem (input phase, input mem_op, input map_ref, input high_address_bus,
        input y_bus, output read_data, output error);
endinterface : mspk_mem_if

// ===== rtl/mspk_alu_byte.sv
// Purpose: one 8-bit slice of the bit-slice ALU
// Assumes: carry convention: subtract is add of complement with carry in
// Notes: functions 3..7 are logical and give carry out from the adder anyway
`timescale 1ns/100ps
module mspk_alu_byte
    import mspk_pkg::*;
(
    input wire logic [7:0] r_i,
    input wire logic [7:0] s_i,
    input wire logic [2:0] fn_i,
    input wire logic cin_i,
    output logic [7:0] f_o,
    output logic cout_o
);
    logic [8:0] sum;
    always_comb
    begin
        sum = 9'h000;
        f_o = 8'h00;
        case (fn_i)
            MSPK_FN_ADD: sum = {1'b0, r_i} + {1'b0, s_i} + {8'h00, cin_i};
            MSPK_FN_SUBR: sum = {1'b0, s_i} + {1'b0, ~r_i} + {8'h00, cin_i};
            MSPK_FN_SUBS: sum = {1'b0, r_i} + {1'b0, ~s_i} + {8'h00, cin_i};
            default: sum = {1'b0, r_i} + {1'b0, s_i} + {8'h00, cin_i};
        endcase
        case (fn_i)
            MSPK_FN_OR: f_o = r_i | s_i;
            MSPK_FN_AND: f_o = r_i & s_i;
            MSPK_FN_NOTRS: f_o = ~r_i & s_i;
            MSPK_FN_XOR: f_o = r_i ^ s_i;
            MSPK_FN_XNOR: f_o = ~(r_i ^ s_i);
            default: f_o = sum[7:0];
        endcase
    end
    assign cout_o = sum[8];
endmodule : mspk_alu_byte

// ===== rtl/mspk_cpu_end.sv
// Purpose: stack pointer, byte-index carry and memory issue of the processor slice
// Assumes: register operands come from the surrounding datapath each cycle
// Notes: function codes 4..7 make the forced upper function 7 (xnor with 0 = complement)
`timescale 1ns/100ps
module mspk_cpu_end
    import mspk_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    mspk_mem_if.cpu mem,
    input wire logic [2:0] push_req_i,
    input wire logic [1:0] pop_req_i,
    input wire logic index_load_i,
    input wire logic carry_from_byte_index_x_i,
    input wire logic carry_from_byte_index_z_i,
    input wire logic carry_in_field_i,
    input wire logic mem_bit_i,
    input wire logic map_ref_i,
    input wire logic write_data_op_i,
    input wire logic opcode_dispatch_i,
    input wire logic direct_a_path_i,
    input wire logic [2:0] alu_source_sel_i,
    input wire logic [2:0] alu_function_sel_i,
    input wire logic [15:0] a_reg_i,
    input wire logic [15:0] b_reg_i,
    input wire logic [15:0] q_reg_i,
    input wire logic [15:0] d_bus_i,
    input wire logic [3:0] b_reg_select_i,
    input wire logic high_reg_write_i,
    input wire logic [7:0] high_reg_wdata_i,
    input wire logic display_busy_i,
    output logic [3:0] push_pop_index_o,
    output logic byte_index_bit_o,
    output logic [1:0] phase_o,
    output logic [15:0] alu_f_o,
    output logic [15:0] y_bus_o,
    output logic [MSPK_AW-1:0] real_addr_o,
    output logic page_crossing_o,
    output logic write_cancel_o,
    output logic dispatch_cancel_o,
    output logic click_suspend_o,
    output logic [15:0] read_data_o
);
    logic [3:0] index_reg;
    logic [3:0] index_next;
    logic bidx_reg;
    logic [1:0] phase_reg;
    logic [7:0] high_regs [MSPK_NRH];
    logic cross_reg;
    logic suspend_reg;
    logic [15:0] rdata_reg;
    logic any_push;
    logic any_pop;
    logic carry_use;
    logic issue;
    logic [7:0] rh;
    logic [15:0] r_op;
    logic [15:0] s_op;
    logic [2:0] hi_fn;
    logic [7:0] hi_r;
    logic [7:0] hi_s;
    logic [7:0] f_hi;
    logic [7:0] f_lo;
    logic c_lo;
    logic c_hi;
    logic [15:0] yv;

    assign any_push = |push_req_i;
    assign any_pop = |pop_req_i;
    // is microcode's duty: z form is only honoured when the carry field is one
    assign carry_use = carry_from_byte_index_x_i
        | (carry_from_byte_index_z_i & carry_in_field_i);
    assign issue = mem_bit_i & (phase_reg == MSPK_PH_C1);

    // loaded value is the base; same-cycle push/pop applies on top of it
    always_comb
    begin
        index_next = index_load_i ? yv[3:0] : index_reg;
        if (any_push && !any_pop)
            index_next = index_next + 4'h1;
        else if (any_pop && !any_push)
            index_next = index_next - 4'h1;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            index_reg <= MSPK_PTR_RST;
        else
            index_reg <= index_next;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            bidx_reg <= 1'b0;
        else if (carry_use)
            bidx_reg <= ~bidx_reg;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            phase_reg <= MSPK_PH_C1;
        else if (phase_reg == MSPK_PH_C3)
            phase_reg <= MSPK_PH_C1;
        else
            phase_reg <= phase_reg + 2'h1;
    end

    // the register file is read every cycle; blocking writes on issue avoids read/write clash
    always_ff @(posedge clk_i)
    begin
        if (high_reg_write_i && !issue && !(map_ref_i && phase_reg == MSPK_PH_C1))
            high_regs[b_reg_select_i] <= high_reg_wdata_i;
    end
    assign rh = high_regs[b_reg_select_i];

    always_comb
    begin
        case (alu_source_sel_i)
            MSPK_SRC_AQ: {r_op, s_op} = {a_reg_i, q_reg_i};
            MSPK_SRC_AB: {r_op, s_op} = {a_reg_i, b_reg_i};
            MSPK_SRC_ZQ: {r_op, s_op} = {16'h0000, q_reg_i};
            MSPK_SRC_ZB: {r_op, s_op} = {16'h0000, b_reg_i};
            MSPK_SRC_ZA: {r_op, s_op} = {16'h0000, a_reg_i};
            MSPK_SRC_DA: {r_op, s_op} = {d_bus_i, a_reg_i};
            MSPK_SRC_DQ: {r_op, s_op} = {d_bus_i, q_reg_i};
            default: {r_op, s_op} = {d_bus_i, 16'h0000};
        endcase
    end

    // split ALU on issue: high half (0,B) with function|3, no carry across
    assign hi_fn = issue ? (alu_function_sel_i | MSPK_FORCE_FN[2:0]) : alu_function_sel_i;
    assign hi_r = issue ? 8'h00 : r_op[15:8];
    assign hi_s = issue ? b_reg_i[15:8] : s_op[15:8];

    mspk_alu_byte u_lo (
        .r_i(r_op[7:0]),
        .s_i(s_op[7:0]),
        .fn_i(alu_function_sel_i),
        .cin_i(bidx_reg & carry_use),
        .f_o(f_lo),
        .cout_o(c_lo)
    );
    mspk_alu_byte u_hi (
        .r_i(hi_r),
        .s_i(hi_s),
        .fn_i(hi_fn),
        .cin_i(issue ? 1'b0 : c_lo),
        .f_o(f_hi),
        .cout_o(c_hi)
    );

    assign alu_f_o = {f_hi, f_lo};
    assign yv = direct_a_path_i ? a_reg_i : {f_hi, f_lo};
    assign y_bus_o = yv;
    assign real_addr_o = {rh[3:0], yv};
    assign page_crossing_o = issue & (c_lo ^ alu_function_sel_i[2]);

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            cross_reg <= 1'b0;
        else
            cross_reg <= page_crossing_o;
    end
    assign write_cancel_o = cross_reg & write_data_op_i;
    assign dispatch_cancel_o = cross_reg & opcode_dispatch_i;

    // suspension is flagged for the whole click started by the issue
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            suspend_reg <= 1'b0;
        else if (phase_reg == MSPK_PH_C1)
            suspend_reg <= issue & (rh[3:0] == 4'h0) & display_busy_i;
    end
    assign click_suspend_o = suspend_reg
        | (issue & (rh[3:0] == 4'h0) & display_busy_i);

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_reg <= 16'h0000;
        else if (mem_bit_i && phase_reg == MSPK_PH_C3)
            rdata_reg <= mem.read_data;
    end

    assign mem.phase = phase_reg;
    assign mem.mem_op = mem_bit_i & ~(phase_reg == MSPK_PH_C2 & cross_reg);
    assign mem.map_ref = map_ref_i & (phase_reg == MSPK_PH_C1);
    assign mem.high_address_bus = rh;
    assign mem.y_bus = yv;
    assign push_pop_index_o = index_reg;
    assign byte_index_bit_o = bidx_reg;
    assign phase_o = phase_reg;
    assign read_data_o = rdata_reg;
endmodule : mspk_cpu_end

// ===== rtl/mspk_mem_end.sv
// Purpose: memory controller card end: real and map references per click
// Assumes: bit 0 of the address bus is the msb; high bits 0-3 ignored on real references, all 8 used on map references
// Notes: storage depth is a parameter; addresses wrap to it
`timescale 1ns/100ps
module mspk_mem_end
    import mspk_pkg::*;
#(
    parameter int ADDR_BITS = 12
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    mspk_mem_if.mem mem,
    input wire logic [15:0] write_data_i,
    output logic access_o
);
    if (ADDR_BITS < 1 || ADDR_BITS > MSPK_AW)
    begin : g_depth_check
        $error("ADDR_BITS out of range");
    end
    logic [15:0] store [2**ADDR_BITS];
    logic armed_reg;
    logic [MSPK_AW-1:0] addr_reg;
    logic [15:0] rdata_reg;
    logic [MSPK_AW-1:0] req_addr;

    // map references drop the low byte and index the table
    assign req_addr = mem.map_ref
        ? MSPK_MAP_BASE + {4'h0, mem.high_address_bus, mem.y_bus[15:8]}
        : {mem.high_address_bus[3:0], mem.y_bus};
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            armed_reg <= 1'b0;
            addr_reg <= 20'h0_0000;
        end
        else if (mem.phase == MSPK_PH_C1)
        begin
            armed_reg <= mem.mem_op | mem.map_ref;
            addr_reg <= req_addr;
        end
    end
    // read captured before any c2 write of this click: old contents returned
    always_ff @(posedge clk_i)
    begin
        if (mem.phase == MSPK_PH_C1)
            rdata_reg <= store[req_addr[ADDR_BITS-1:0]];
        if (armed_reg && mem.mem_op && mem.phase == MSPK_PH_C2)
            store[addr_reg[ADDR_BITS-1:0]] <= write_data_i;
    end
    assign mem.read_data = rdata_reg;
    assign mem.error = 1'b0;
    assign access_o = armed_reg;
endmodule : mspk_mem_end

// ===== testbench/mspk_link_asserts.sv
// Purpose: click phase and link checks on the memory interface
// Assumes: one clock, reset asynchronous active high
// Notes: sees only the link signals, so datapath values are left to the bench
`timescale 1ns/100ps
module mspk_link_asserts
    import mspk_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] phase,
    input wire logic mem_op,
    input wire logic map_ref,
    input wire logic [7:0] high_address_bus,
    input wire logic [15:0] y_bus,
    input wire logic [15:0] read_data,
    input wire logic error
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // the edge that releases reset still sees the held phase, so it is skipped
    sequence s_click_start;
        !$past(rst_i) && phase == MSPK_PH_C1;
    endsequence
    sequence s_click_body;
        phase == MSPK_PH_C2 ##1 phase == MSPK_PH_C3 ##1 phase == MSPK_PH_C1;
    endsequence
    a_click_runs_whole: assert property (s_click_start |=> s_click_body)
        else $error("click phases out of order");
    a_c2_then_c3: assert property (phase == MSPK_PH_C2 |=> phase == MSPK_PH_C3)
        else $error("third cycle missing after second");
    a_c3_wraps: assert property (phase == MSPK_PH_C3 |=> phase == MSPK_PH_C1)
        else $error("click did not wrap to first cycle");
    a_phase_legal: assert property (phase != 2'h3)
        else $error("illegal phase code");
    a_never_stalls: assert property (!$past(rst_i) |-> phase != $past(phase))
        else $error("phase stood still");
    a_reset_in_c1: assert property ($fell(rst_i) |-> phase == MSPK_PH_C1)
        else $error("first cycle after reset is not c1");
    a_error_quiet: assert property (!error)
        else $error("memory error raised");
    a_map_in_c1: assert property (map_ref |-> phase == MSPK_PH_C1)
        else $error("map reference outside first cycle");
endmodule : mspk_link_asserts

// ===== testbench/micro_stack_carry_memref_tb.sv
// Purpose: drives both ends of the memory link and checks the slice at its ports
// Assumes: every input changes by nonblocking assignment at the rising edge
// Notes: q operand tied low; memory array is not reset, so reads follow writes
`timescale 1ns/100ps
module micro_stack_carry_memref_tb
    import mspk_pkg::*;
;
    typedef struct packed {
        logic [2:0] pu; logic [1:0] po; logic ld, cx, cz, cin, mb, mapr, wdo, disp, dap;
        logic [2:0] src; logic [2:0] fn; logic [15:0] a, b, d; logic [3:0] bsel;
        logic hw; logic [7:0] hwd; logic dbusy; logic [15:0] wd;
    } mspk_tb_stim_s;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    mspk_tb_stim_s st = '0;
    mspk_tb_stim_s s;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [3:0] idx;
    logic bib, pc, wc, dc, sus, spc, ssus, swc, sdc, acc, sacc;
    logic [1:0] ph;
    logic [15:0] af, yb, rd, sf;
    logic [MSPK_AW-1:0] ra, sa;
    // rows: push fields, pop fields, expected index afterwards
    logic [8:0] rows [7] = '{9'h03F, 9'h07F, 9'h1C0, 9'h041, 9'h102, 9'h0A2, 9'h1D2};
    mspk_mem_if mspk_mem_if_i ();
    mspk_cpu_end mspk_cpu_end_i (.clk_i(clk_i), .rst_i(rst_i), .mem(mspk_mem_if_i),
        .push_req_i(st.pu), .pop_req_i(st.po), .index_load_i(st.ld),
        .carry_from_byte_index_x_i(st.cx), .carry_from_byte_index_z_i(st.cz),
        .carry_in_field_i(st.cin), .mem_bit_i(st.mb), .map_ref_i(st.mapr),
        .write_data_op_i(st.wdo), .opcode_dispatch_i(st.disp), .direct_a_path_i(st.dap),
        .alu_source_sel_i(st.src), .alu_function_sel_i(st.fn), .a_reg_i(st.a),
        .b_reg_i(st.b), .q_reg_i(16'h0000), .d_bus_i(st.d), .b_reg_select_i(st.bsel),
        .high_reg_write_i(st.hw), .high_reg_wdata_i(st.hwd), .display_busy_i(st.dbusy),
        .push_pop_index_o(idx), .byte_index_bit_o(bib), .phase_o(ph), .alu_f_o(af),
        .y_bus_o(yb), .real_addr_o(ra), .page_crossing_o(pc), .write_cancel_o(wc),
        .dispatch_cancel_o(dc), .click_suspend_o(sus), .read_data_o(rd));
    mspk_mem_end mspk_mem_end_i (.clk_i(clk_i), .rst_i(rst_i), .mem(mspk_mem_if_i),
        .write_data_i(st.wd), .access_o(acc));
    mspk_link_asserts mspk_link_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
        .phase(mspk_mem_if_i.phase), .mem_op(mspk_mem_if_i.mem_op),
        .map_ref(mspk_mem_if_i.map_ref), .high_address_bus(mspk_mem_if_i.high_address_bus),
        .y_bus(mspk_mem_if_i.y_bus), .read_data(mspk_mem_if_i.read_data),
        .error(mspk_mem_if_i.error));
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic cyc(input mspk_tb_stim_s v);
        @(posedge clk_i);
        st <= v;
        #1;
    endtask : cyc
    // one whole click: issue cycle from c, then optional write and read cycles
    task automatic mclick(input mspk_tb_stim_s c, input logic wr, input logic rdo,
        input logic [15:0] w);
        for (int k = 0; k < 3; k++)
            if (ph !== MSPK_PH_C3)
                cyc('0);
        cyc(c);
        sa = ra;
        sf = af;
        spc = pc;
        ssus = sus;
        c.mb = wr;
        c.wdo = wr;
        c.disp = wr;
        c.hw = 1'b0;
        c.mapr = 1'b0;
        c.wd = w;
        cyc(c);
        swc = wc;
        sacc = acc;
        sdc = dc;
        c.mb = rdo;
        c.wdo = 1'b0;
        c.disp = 1'b0;
        cyc(c);
        cyc('0);
    endtask : mclick
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            err_total++;
            test_done();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk("reset phase", ph, MSPK_PH_C1);
        chk("reset index", idx, MSPK_PTR_RST);
        foreach (rows[i])
        begin
            s = '0;
            {s.pu, s.po} = rows[i][8:4];
            cyc(s);
            cyc('0);
            chk("stack index", idx, rows[i][3:0]);
        end
        $display("test push_pop done");
        s = '0;
        s.dap = 1'b1;
        s.a = 16'h000A;
        s.ld = 1'b1;
        cyc(s);
        chk("y bus bypass", yb, 16'h000A);
        s.ld = 1'b0;
        s.pu = 3'h1;
        cyc(s);
        chk("loaded index", idx, 4'hA);
        cyc('0);
        chk("pushed load", idx, 4'hB);
        $display("test load done");
        s = '0;
        s.src = MSPK_SRC_DZ;
        s.fn = MSPK_FN_ADD;
        s.d = 16'h00FF;
        s.cx = 1'b1;
        s.cin = 1'b1;
        cyc(s);
        chk("alu without carry", af, 16'h00FF);
        cyc(s);
        chk("alu with carry", af, 16'h0100);
        s.cx = 1'b0;
        s.cz = 1'b1;
        s.cin = 1'b0;
        cyc(s);
        chk("byte index", bib, 1'b0);
        s.cin = 1'b1;
        cyc(s);
        chk("z form refused", bib, 1'b0);
        cyc('0);
        chk("z form taken", bib, 1'b1);
        $display("test byte index done");
        s = '0;
        s.hw = 1'b1;
        s.bsel = 4'h7;
        s.hwd = 8'hF0;
        cyc(s);
        s.bsel = 4'h3;
        s.hwd = 8'h05;
        cyc(s);
        s = '0;
        s.bsel = 4'h3;
        s.b = 16'h1200;
        s.src = MSPK_SRC_DA;
        s.fn = MSPK_FN_ADD;
        s.mb = 1'b1;
        mclick(s, 1'b1, 1'b0, 16'h4444);
        chk("issue address", sa, 20'h5_1200);
        chk("access armed", sacc, 1'b1);
        s.a = 16'h0040;
        s.dbusy = 1'b1;
        s.hw = 1'b1;
        s.hwd = 8'h0F;
        mclick(s, 1'b1, 1'b0, 16'hBEEF);
        chk("split alu", sf, 16'h1240);
        chk("no crossing", spc, 1'b0);
        chk("no suspend", ssus, 1'b0);
        s.hw = 1'b0;
        s.dbusy = 1'b0;
        mclick(s, 1'b1, 1'b1, 16'h1357);
        chk("old word first", rd, 16'hBEEF);
        chk("high reg kept", sa, 20'h5_1240);
        s.dap = 1'b1;
        s.a = 16'h0240;
        mclick(s, 1'b0, 1'b1, 16'h0000);
        chk("read back", rd, 16'h1357);
        chk("bypass address", sa, 20'h5_0240);
        chk("bypass high byte", sf[15:8], 8'h12);
        s.dap = 1'b0;
        s.d = 16'h00C0;
        s.a = 16'h0040;
        mclick(s, 1'b1, 1'b0, 16'hDEAD);
        chk("carry kept low", sf, 16'h1200);
        chk("crossing", spc, 1'b1);
        chk("write cancel", swc, 1'b1);
        chk("dispatch cancel", sdc, 1'b1);
        s.mb = 1'b0;
        s.dap = 1'b1;
        s.a = 16'h1200;
        mclick(s, 1'b1, 1'b1, 16'hF00D);
        chk("no access", sacc, 1'b0);
        s.mb = 1'b1;
        mclick(s, 1'b0, 1'b1, 16'h0000);
        chk("untouched word", rd, 16'h4444);
        s.bsel = 4'h7;
        s.dbusy = 1'b1;
        mclick(s, 1'b0, 1'b0, 16'h0000);
        chk("suspend", ssus, 1'b1);
        s.mb = 1'b0;
        s.mapr = 1'b1;
        s.dbusy = 1'b0;
        mclick(s, 1'b1, 1'b0, 16'hCAFE);
        // map slot of high byte f0 and y high byte 12, folded into the 12-bit store
        s.mb = 1'b1;
        s.mapr = 1'b0;
        s.a = 16'h0012;
        mclick(s, 1'b0, 1'b1, 16'h0000);
        chk("map entry", rd, 16'hCAFE);
        $display("test memory clicks done");
        @(posedge clk_i);
        rst_i <= 1'b1;
        #1;
        chk("rearm index", idx, MSPK_PTR_RST);
        chk("rearm phase", ph, MSPK_PH_C1);
        @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) cyc('0);
        chk("phase after reset", ph, MSPK_PH_C2);
        $display("test reset done");
        test_done();
    end
endmodule : micro_stack_carry_memref_tb
